// file: pkg/afeu_pkg.sv
// Notes on behaviour
// - Data access fault vectors to 00300 and records causes as bits in the cause register.
// - Not-found bit set when no hash group or block translation entry translates.
// - Protection bit set when page or block protection forbids the data access.
// - I/O-segment bit set for reserve/compare/external-control access to I/O segments.
// - I/O-segment bit also set by external-control access to write-through addresses.
// - Direction bit set for a faulting store, cleared for a faulting load.
// - Breakpoint address match under an enabled mode sets breakpoint bit and faults.
// - External-access-disabled bit set for external-control access while enable clear.
// - Untranslatable instruction fetch takes instruction access exception at 00400.
// - Instruction fetch from an I/O segment takes instruction access exception.
// - Fetch refused with instruction access exception when keys and protection forbid read.
// - Asserted interrupt input leads to external interrupt exception at 00500.
// - Floating-point operand in an I/O segment takes alignment exception at 00600.
// - Scalar operand crossing a page boundary takes alignment exception.
// - External interrupt is software maskable and taken precisely.
// - Asynchronous exception waits until in-flight instructions have completed.
`default_nettype none
package afeu_pkg;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_BKPT = 4'h4;
  localparam logic [3:0] REG_CAUSE = 4'h8;
  localparam logic [3:0] REG_LAST = 4'hc;
  // Control register fields
  localparam int CTRL_INT_EN = 0;
  localparam int CTRL_EXT_EN = 1;
  localparam int CTRL_BK_LOAD = 2;
  localparam int CTRL_BK_STORE = 3;
  localparam int CTRL_BK_ANY = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // Cause register fields
  localparam int CAUSE_NOT_FOUND = 0;
  localparam int CAUSE_PROTECT = 1;
  localparam int CAUSE_IO_SEG = 2;
  localparam int CAUSE_STORE = 3;
  localparam int CAUSE_BKPT = 4;
  localparam int CAUSE_EXT_DIS = 5;
  localparam int CAUSE_W = 6;
  localparam logic [5:0] CAUSE_RESET = 6'h00;
  // Vector offsets
  localparam int VEC_W = 20;
  localparam logic [19:0] VEC_DATA = 20'h00300;
  localparam logic [19:0] VEC_INSTR = 20'h00400;
  localparam logic [19:0] VEC_EXT = 20'h00500;
  localparam logic [19:0] VEC_ALIGN = 20'h00600;
  localparam logic [19:0] VEC_NONE = 20'h00000;
  localparam logic [31:0] BKPT_RESET = 32'h00000000;
  localparam logic [1:0] PP_NO_ACCESS = 2'h0;

  typedef struct packed {
    logic valid;
    logic [31:0] effective_addr;
    logic is_store;
    logic no_translation;
    logic prot_violation;
    logic segment_io_flag;
    logic ext_control_op;
    logic reserve_or_compare_op;
    logic write_through;
    logic fp_op;
    logic crosses_page;
  } afeu_data_req_s;

  typedef struct packed {
    logic valid;
    logic no_translation;
    logic segment_io_flag;
    logic user_mode;
    logic supervisor_key_bit;
    logic user_key_bit;
    logic [1:0] page_protection_bits;
  } afeu_fetch_req_s;
endpackage
`default_nettype wire

// file: rtl/afeu_top.sv
// The implementer's own choices: the strobed register port and the address map.
`default_nettype none
module afeu_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire afeu_pkg::afeu_data_req_s data_req,
  input wire afeu_pkg::afeu_fetch_req_s fetch_req,
  input wire logic pipe_drained,
  input wire logic ext_int_pin,
  output logic exc_valid,
  output logic [19:0] exc_vector,
  output logic [5:0] data_fault_cause_reg
);
  logic [4:0] ctrl;
  logic [31:0] data_breakpoint_addr_reg;
  logic [19:0] last_vector;
  logic int_s1, int_s2, int_s3, int_lvl;
  logic bk_hit, io_hit, ext_dis, data_fault, align_fault;
  logic read_prot, fetch_fault, ext_take;
  logic [5:0] next_cause;
  logic [19:0] next_vector;

  // Interrupt pin is asynchronous: three flops, accept when last two agree
  always_ff @(posedge core_clk) begin
    if (reset) begin
      int_s1 <= 1'b0;
      int_s2 <= 1'b0;
      int_s3 <= 1'b0;
    end else begin
      int_s1 <= ext_int_pin;
      int_s2 <= int_s1;
      int_s3 <= int_s2;
    end
  end

  // Filtered level ignores single-cycle disagreement
  always_ff @(posedge core_clk) begin
    if (reset) begin
      int_lvl <= 1'b0;
    end else if (int_s2 == int_s3) begin
      int_lvl <= int_s3;
    end
  end

  // Breakpoint compares word address under each enabled mode
  always_comb begin
    bk_hit = data_req.valid &&
      (data_req.effective_addr[31:2] == data_breakpoint_addr_reg[31:2]) &&
      ((ctrl[afeu_pkg::CTRL_BK_LOAD] && !data_req.is_store) ||
       (ctrl[afeu_pkg::CTRL_BK_STORE] && data_req.is_store) ||
       ctrl[afeu_pkg::CTRL_BK_ANY]);
  end

  // I/O segment and external access checks
  always_comb begin
    io_hit = (data_req.segment_io_flag &&
      (data_req.ext_control_op || data_req.reserve_or_compare_op)) ||
      (data_req.ext_control_op && data_req.write_through);
    ext_dis = data_req.ext_control_op && !ctrl[afeu_pkg::CTRL_EXT_EN];
  end

  // All cause bits assembled together for one write
  always_comb begin
    next_cause = afeu_pkg::CAUSE_RESET;
    next_cause[afeu_pkg::CAUSE_NOT_FOUND] = data_req.no_translation;
    next_cause[afeu_pkg::CAUSE_PROTECT] = data_req.prot_violation;
    next_cause[afeu_pkg::CAUSE_IO_SEG] = io_hit;
    next_cause[afeu_pkg::CAUSE_STORE] = data_req.is_store;
    next_cause[afeu_pkg::CAUSE_BKPT] = bk_hit;
    next_cause[afeu_pkg::CAUSE_EXT_DIS] = ext_dis;
    data_fault = data_req.valid && (data_req.no_translation ||
      data_req.prot_violation || io_hit || bk_hit || ext_dis);
  end

  // Alignment only when no data access cause applies
  always_comb begin
    align_fault = data_req.valid && !data_fault &&
      ((data_req.fp_op && data_req.segment_io_flag) ||
       (!data_req.fp_op && data_req.crosses_page));
  end

  // Read is forbidden when the active key is set and protection is none
  always_comb begin
    read_prot = (fetch_req.user_mode ? fetch_req.user_key_bit :
      fetch_req.supervisor_key_bit) &&
      (fetch_req.page_protection_bits == afeu_pkg::PP_NO_ACCESS);
    fetch_fault = fetch_req.valid && (fetch_req.no_translation ||
      fetch_req.segment_io_flag || read_prot);
  end

  // External interrupt waits for a drained pipe and no synchronous fault
  always_comb begin
    ext_take = int_lvl && ctrl[afeu_pkg::CTRL_INT_EN] &&
      pipe_drained && !fetch_fault && !data_fault && !align_fault;
  end

  // Fetch faults first, then data, alignment, external
  always_comb begin
    if (fetch_fault) begin
      next_vector = afeu_pkg::VEC_INSTR;
    end else if (data_fault) begin
      next_vector = afeu_pkg::VEC_DATA;
    end else if (align_fault) begin
      next_vector = afeu_pkg::VEC_ALIGN;
    end else if (ext_take) begin
      next_vector = afeu_pkg::VEC_EXT;
    end else begin
      next_vector = afeu_pkg::VEC_NONE;
    end
  end

  // Exception pulse and vector, one cycle per taken exception
  always_ff @(posedge core_clk) begin
    if (reset) begin
      exc_valid <= 1'b0;
      exc_vector <= afeu_pkg::VEC_NONE;
    end else begin
      exc_valid <= fetch_fault || data_fault || align_fault || ext_take;
      exc_vector <= next_vector;
    end
  end

  // Last vector taken, kept for software
  always_ff @(posedge core_clk) begin
    if (reset) begin
      last_vector <= afeu_pkg::VEC_NONE;
    end else if (next_vector != afeu_pkg::VEC_NONE) begin
      last_vector <= next_vector;
    end
  end

  // Cause register written whole, only by a data fault
  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_fault_cause_reg <= afeu_pkg::CAUSE_RESET;
    end else if (data_fault && !fetch_fault) begin
      data_fault_cause_reg <= next_cause;
    end
  end

  // Control: taking the interrupt masks it, and that wins over a write
  // so a level that is still high cannot re-enter the handler at once
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl <= afeu_pkg::CTRL_RESET;
    end else if (ext_take && !fetch_fault) begin
      ctrl[afeu_pkg::CTRL_INT_EN] <= 1'b0;
    end else if (reg_wr && reg_addr == afeu_pkg::REG_CTRL) begin
      ctrl <= reg_wdata[afeu_pkg::CTRL_W-1:0];
    end
  end

  // Breakpoint address register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_breakpoint_addr_reg <= afeu_pkg::BKPT_RESET;
    end else if (reg_wr && reg_addr == afeu_pkg::REG_BKPT) begin
      data_breakpoint_addr_reg <= reg_wdata;
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (reset || !reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else begin
      unique case (reg_addr)
        afeu_pkg::REG_CTRL: reg_rdata <= {27'h0000000, ctrl};
        afeu_pkg::REG_BKPT: reg_rdata <= data_breakpoint_addr_reg;
        afeu_pkg::REG_CAUSE: reg_rdata <= {26'h0000000, data_fault_cause_reg};
        afeu_pkg::REG_LAST: reg_rdata <= {12'h000, last_vector};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_data_vector: assert property (data_req.valid && data_fault && !fetch_req.valid
    |=> exc_valid && exc_vector == afeu_pkg::VEC_DATA)
    else $error("data fault did not vector to 300");
  a_notfound_bit: assert property (data_fault && !fetch_fault
    |=> data_fault_cause_reg[afeu_pkg::CAUSE_NOT_FOUND] == $past(data_req.no_translation))
    else $error("not-found cause bit wrong");
  a_protect_bit: assert property (data_fault && !fetch_fault
    |=> data_fault_cause_reg[afeu_pkg::CAUSE_PROTECT] == $past(data_req.prot_violation))
    else $error("protection cause bit wrong");
  a_ioseg_bit: assert property (data_req.valid && data_req.segment_io_flag &&
    data_req.reserve_or_compare_op && !fetch_fault
    |=> data_fault_cause_reg[afeu_pkg::CAUSE_IO_SEG])
    else $error("I/O segment cause bit not set");
  a_wthru_bit: assert property (data_req.valid && data_req.ext_control_op &&
    data_req.write_through && !fetch_fault
    |=> data_fault_cause_reg[afeu_pkg::CAUSE_IO_SEG])
    else $error("write-through cause bit not set");
  a_store_bit: assert property (data_fault && !fetch_fault
    |=> data_fault_cause_reg[afeu_pkg::CAUSE_STORE] == $past(data_req.is_store))
    else $error("direction cause bit wrong");
  a_bkpt_hit: assert property (data_req.valid && ctrl[afeu_pkg::CTRL_BK_ANY] &&
    data_req.effective_addr[31:2] == data_breakpoint_addr_reg[31:2] && !fetch_fault
    |=> exc_vector == afeu_pkg::VEC_DATA && data_fault_cause_reg[afeu_pkg::CAUSE_BKPT])
    else $error("breakpoint match not reported");
  a_extdis_bit: assert property (data_req.valid && data_req.ext_control_op &&
    !ctrl[afeu_pkg::CTRL_EXT_EN] && !fetch_fault
    |=> data_fault_cause_reg[afeu_pkg::CAUSE_EXT_DIS])
    else $error("external disabled bit not set");
  a_fetch_vector: assert property (fetch_req.valid && (fetch_req.no_translation ||
    fetch_req.segment_io_flag) |=> exc_valid && exc_vector == afeu_pkg::VEC_INSTR)
    else $error("fetch fault did not vector to 400");
  a_fetch_prot: assert property (fetch_req.valid && !fetch_req.user_mode &&
    fetch_req.supervisor_key_bit && fetch_req.page_protection_bits == afeu_pkg::PP_NO_ACCESS
    |=> exc_vector == afeu_pkg::VEC_INSTR)
    else $error("read protected fetch not refused");
  a_ext_vector: assert property (exc_valid && exc_vector == afeu_pkg::VEC_EXT
    |-> $past(int_lvl) && $past(ctrl[afeu_pkg::CTRL_INT_EN]) && !ctrl[afeu_pkg::CTRL_INT_EN])
    else $error("external interrupt taken without enabled request");
  a_ext_drain: assert property (exc_valid && exc_vector == afeu_pkg::VEC_EXT
    |-> $past(pipe_drained))
    else $error("external interrupt taken before drain");
  a_align_fp: assert property (data_req.valid && !data_fault && data_req.fp_op &&
    data_req.segment_io_flag && !fetch_fault |=> exc_vector == afeu_pkg::VEC_ALIGN)
    else $error("fp I/O operand not aligned fault");
  a_align_page: assert property (data_req.valid && !data_fault && !data_req.fp_op &&
    data_req.crosses_page && !fetch_fault |=> exc_vector == afeu_pkg::VEC_ALIGN)
    else $error("page crossing not aligned fault");
  a_cause_whole: assert property (data_fault && !fetch_fault
    |=> data_fault_cause_reg == $past(next_cause))
    else $error("cause bits not written together");

  // Vector reads zero whenever no exception is reported
  a_vec_idle: assert property (!exc_valid
    |-> exc_vector == afeu_pkg::VEC_NONE)
    else $error("vector shown without exception");
  // Every pulse has a cause in the reporting cycle before it
  a_pulse_once: assert property (exc_valid
    |-> $past(fetch_fault || data_fault || align_fault || ext_take))
    else $error("exception pulse without cause");
  // Data fault beats alignment and external sources
  a_data_first: assert property (data_fault && !fetch_fault
    |=> exc_valid && exc_vector == afeu_pkg::VEC_DATA)
    else $error("data fault lost priority");

  // Software read of the cause register shows the live cause bits
  a_cause_read: assert property (reg_rd && reg_addr == afeu_pkg::REG_CAUSE
    |=> reg_rdata[5:0] == $past(data_fault_cause_reg))
    else $error("cause read back wrong");
  // Read data idle when no read was strobed
  a_rdata_zero: assert property (!reg_rd
    |=> reg_rdata == 32'h00000000)
    else $error("read data not idle");
  // Mask state is visible to software
  a_ctrl_read: assert property (reg_rd && reg_addr == afeu_pkg::REG_CTRL
    |=> reg_rdata[4:0] == $past(ctrl))
    else $error("control read back wrong");
  // Last taken vector is visible to software
  a_last_read: assert property (reg_rd && reg_addr == afeu_pkg::REG_LAST
    |=> reg_rdata[19:0] == $past(last_vector))
    else $error("last vector read back wrong");

  // Cause register only moves on a data fault that wins
  a_cause_hold: assert property (!(data_fault && !fetch_fault)
    |=> $stable(data_fault_cause_reg))
    else $error("cause register changed without data fault");
  // I/O-segment bit cleared on a fault with no external-control or reserve/compare access
  a_io_clr: assert property (data_fault && !fetch_fault && !data_req.ext_control_op &&
    !data_req.reserve_or_compare_op |=> !data_fault_cause_reg[afeu_pkg::CAUSE_IO_SEG])
    else $error("I/O segment bit not cleared");
  // Store sets the direction bit
  a_store_set: assert property (data_fault && !fetch_fault && data_req.is_store
    |=> data_fault_cause_reg[afeu_pkg::CAUSE_STORE])
    else $error("store did not set direction bit");
  // Load clears the direction bit
  a_load_clr: assert property (data_fault && !fetch_fault && !data_req.is_store
    |=> !data_fault_cause_reg[afeu_pkg::CAUSE_STORE])
    else $error("load did not clear direction bit");

  // Load compare mode matches loads only
  a_bkpt_load: assert property (data_req.valid && ctrl[afeu_pkg::CTRL_BK_LOAD] &&
    !data_req.is_store && data_req.effective_addr[31:2] == data_breakpoint_addr_reg[31:2] &&
    !fetch_fault |=> data_fault_cause_reg[afeu_pkg::CAUSE_BKPT])
    else $error("load breakpoint not reported");
  // Store compare mode matches stores only
  a_bkpt_store: assert property (data_req.valid && ctrl[afeu_pkg::CTRL_BK_STORE] &&
    data_req.is_store && data_req.effective_addr[31:2] == data_breakpoint_addr_reg[31:2] &&
    !fetch_fault |=> data_fault_cause_reg[afeu_pkg::CAUSE_BKPT])
    else $error("store breakpoint not reported");
  // No compare mode enabled, no breakpoint bit
  a_bkpt_off: assert property (data_fault && !fetch_fault && ctrl[4:2] == 3'h0
    |=> !data_fault_cause_reg[afeu_pkg::CAUSE_BKPT])
    else $error("breakpoint bit set with compare off");
  // Different word address never matches
  a_bkpt_miss: assert property (data_fault && !fetch_fault &&
    data_req.effective_addr[31:2] != data_breakpoint_addr_reg[31:2]
    |=> !data_fault_cause_reg[afeu_pkg::CAUSE_BKPT])
    else $error("breakpoint bit set on address mismatch");
  // External access enabled leaves the disabled bit clear
  a_extdis_clr: assert property (data_fault && !fetch_fault && ctrl[afeu_pkg::CTRL_EXT_EN]
    |=> !data_fault_cause_reg[afeu_pkg::CAUSE_EXT_DIS])
    else $error("external disabled bit set while enabled");

  // Fetch fault always vectors to the instruction handler
  a_fetch_first: assert property (fetch_fault
    |=> exc_valid && exc_vector == afeu_pkg::VEC_INSTR)
    else $error("fetch fault lost priority");
  // Fetch fault never disturbs the data cause bits
  a_fetch_keep: assert property (fetch_fault
    |=> $stable(data_fault_cause_reg))
    else $error("fetch fault changed cause register");
  // Fetch from an I/O segment is never performed
  a_fetch_io: assert property (fetch_req.valid && fetch_req.segment_io_flag
    |=> exc_vector == afeu_pkg::VEC_INSTR)
    else $error("I/O segment fetch not refused");
  // User key with no-access protection refuses the fetch
  a_fetch_user: assert property (fetch_req.valid && fetch_req.user_mode &&
    fetch_req.user_key_bit && fetch_req.page_protection_bits == afeu_pkg::PP_NO_ACCESS
    |=> exc_vector == afeu_pkg::VEC_INSTR)
    else $error("user read protected fetch not refused");

  // Alignment vector only when no data cause held
  a_align_vector: assert property (exc_valid && exc_vector == afeu_pkg::VEC_ALIGN
    |-> $past(data_req.valid) && !$past(data_fault))
    else $error("alignment taken over data fault");

  // Filtered level moves only when stages two and three agree
  a_int_filter: assert property (int_lvl != $past(int_lvl)
    |-> $past(int_s2) == $past(int_s3))
    else $error("interrupt level moved on disagreement");
  // No filtered request, no external exception
  a_ext_filtered: assert property (!int_lvl
    |=> !(exc_valid && exc_vector == afeu_pkg::VEC_EXT))
    else $error("external taken without request");
  // Masked request is never taken
  a_ext_masked: assert property (!ctrl[afeu_pkg::CTRL_INT_EN]
    |=> !(exc_valid && exc_vector == afeu_pkg::VEC_EXT))
    else $error("masked interrupt taken");
  // Instructions in flight hold the interrupt off
  a_ext_busy: assert property (!pipe_drained
    |=> !(exc_valid && exc_vector == afeu_pkg::VEC_EXT))
    else $error("interrupt taken with pipe busy");
  // Synchronous faults are served before the interrupt
  a_ext_lowest: assert property (exc_valid && exc_vector == afeu_pkg::VEC_EXT
    |-> !$past(fetch_fault) && !$past(data_fault) && !$past(align_fault))
    else $error("interrupt taken over synchronous fault");

  c_data_fault: cover property (exc_valid && exc_vector == afeu_pkg::VEC_DATA);
  c_multi_cause: cover property (data_fault && io_hit && bk_hit);
  c_ext_taken: cover property (exc_valid && exc_vector == afeu_pkg::VEC_EXT);
  c_align: cover property (exc_valid && exc_vector == afeu_pkg::VEC_ALIGN);
  // Fetch fault hiding a data fault in the same cycle
  c_fetch_over_data: cover property (fetch_fault && data_fault);
endmodule
`default_nettype wire

// file: testbench/afeu_pipe_model.sv
`default_nettype none
// Pipeline and interrupt source on the far side of the exception unit
module afeu_pipe_model (
  input wire logic core_clk,
  output logic ext_int_pin,
  output logic pipe_drained
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle source, empty pipeline until a test says otherwise
  initial begin
    ext_int_pin = 1'b0;
    pipe_drained = 1'b1;
  end
  // Request is a level, held until the handler quiets the source
  task automatic set_int(input logic v);
    @(posedge core_clk);
    ext_int_pin <= v;
  endtask
  // Low models instructions still in flight, which must hold off the interrupt
  task automatic set_drained(input logic v);
    @(posedge core_clk);
    pipe_drained <= v;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_access_fault_exception_unit.sv
`default_nettype none
module tb_access_fault_exception_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  afeu_pkg::afeu_data_req_s data_req = '0;
  afeu_pkg::afeu_fetch_req_s fetch_req = '0;
  logic pipe_drained;
  logic ext_int_pin;
  logic exc_valid;
  logic [19:0] exc_vector;
  logic [5:0] data_fault_cause_reg;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  // Clock at 40 MHz
  always #12.5 core_clk = ~core_clk;
  afeu_top u_afeu_top (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .data_req(data_req), .fetch_req(fetch_req), .pipe_drained(pipe_drained),
    .ext_int_pin(ext_int_pin), .exc_valid(exc_valid), .exc_vector(exc_vector),
    .data_fault_cause_reg(data_fault_cause_reg));
  afeu_pipe_model u_afeu_pipe_model (.core_clk(core_clk), .ext_int_pin(ext_int_pin),
    .pipe_drained(pipe_drained));
  // Hang guard, well above the hundred or so cycles the tests need
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Data bits: store, miss, prot, io, extctl, resv, wthru, fp, cross
  function automatic afeu_pkg::afeu_data_req_s dr(input logic [31:0] ea, input logic [8:0] b);
    dr = {1'b1, ea, b};
  endfunction
  // Fetch bits: miss, io, user, skey, ukey, pp
  function automatic afeu_pkg::afeu_fetch_req_s fr(input logic [6:0] b);
    fr = {1'b1, b};
  endfunction
  // One reporting cycle; the answer lands one cycle later
  task automatic rep(input afeu_pkg::afeu_data_req_s d, input afeu_pkg::afeu_fetch_req_s f,
                     input logic [19:0] ev, input logic [5:0] ec);
    @(posedge core_clk);
    data_req <= d;
    fetch_req <= f;
    @(posedge core_clk);
    data_req <= '0;
    fetch_req <= '0;
    #1;
    chk({31'h0, exc_valid}, {31'h0, ev !== afeu_pkg::VEC_NONE});
    chk({12'h0, exc_vector}, {12'h0, ev});
    chk({26'h0, data_fault_cause_reg}, {26'h0, ec});
  endtask
  // Counts pulses over n cycles; each one must carry the expected vector
  task automatic watch(input int n, input int exp_n, input logic [19:0] ev);
    int k = 0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (exc_valid === 1'b1) begin
        k++;
        chk({12'h0, exc_vector}, {12'h0, ev});
      end
    end
    chk(k, exp_n);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    // Reset values, unmapped address reads zero
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h0);
    rd(4'hc, 32'h0);
    rd(4'h2, 32'h0);
    // Data faults, one cause at a time, then several together, external access still disabled
    rep(dr(32'h0, 9'h080), '0, afeu_pkg::VEC_DATA, 6'h01);
    rep(dr(32'h0, 9'h140), '0, afeu_pkg::VEC_DATA, 6'h0a);
    rep(dr(32'h0, 9'h028), '0, afeu_pkg::VEC_DATA, 6'h04);
    rep(dr(32'h0, 9'h010), '0, afeu_pkg::VEC_DATA, 6'h20);
    rep(dr(32'h0, 9'h1e8), '0, afeu_pkg::VEC_DATA, 6'h0f);
    rd(4'h8, 32'h0000000f);
    // Breakpoint on stores only, external access now enabled
    wr(4'h4, 32'h00001000);
    wr(4'h0, 32'h0000000a);
    rep(dr(32'h0, 9'h014), '0, afeu_pkg::VEC_DATA, 6'h04);
    rep(dr(32'h00001002, 9'h100), '0, afeu_pkg::VEC_DATA, 6'h18);
    rep(dr(32'h00001002, 9'h000), '0, afeu_pkg::VEC_NONE, 6'h18);
    // Load mode, then any mode
    wr(4'h0, 32'h00000006);
    rep(dr(32'h00001003, 9'h000), '0, afeu_pkg::VEC_DATA, 6'h10);
    wr(4'h0, 32'h00000012);
    rep(dr(32'h00001000, 9'h100), '0, afeu_pkg::VEC_DATA, 6'h18);
    // Fetch faults; a fetch fault beats a data fault and leaves the cause alone
    rep('0, fr(7'h40), afeu_pkg::VEC_INSTR, 6'h18);
    rep('0, fr(7'h20), afeu_pkg::VEC_INSTR, 6'h18);
    rep('0, fr(7'h14), afeu_pkg::VEC_INSTR, 6'h18);
    rep('0, fr(7'h08), afeu_pkg::VEC_INSTR, 6'h18);
    rep('0, fr(7'h15), afeu_pkg::VEC_NONE, 6'h18);
    rep(dr(32'h0, 9'h080), fr(7'h40), afeu_pkg::VEC_INSTR, 6'h18);
    // Alignment
    rep(dr(32'h0, 9'h022), '0, afeu_pkg::VEC_ALIGN, 6'h18);
    rep(dr(32'h0, 9'h001), '0, afeu_pkg::VEC_ALIGN, 6'h18);
    // External interrupt: masked, then held off by a busy pipeline
    u_afeu_pipe_model.set_int(1'b1);
    watch(10, 0, afeu_pkg::VEC_NONE);
    u_afeu_pipe_model.set_drained(1'b0);
    wr(4'h0, 32'h0000000b);
    watch(10, 0, afeu_pkg::VEC_NONE);
    u_afeu_pipe_model.set_drained(1'b1);
    watch(6, 1, afeu_pkg::VEC_EXT);
    rd(4'h0, 32'h0000000a);
    rd(4'hc, 32'h00000500);
    u_afeu_pipe_model.set_int(1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
